/* schp_pkg.sv */
// ============================================================
// shared constants for the serial chain port
// ============================================================
package schp_pkg;

    // ============================================================
    // clocking and link timing
    // ============================================================
    localparam int CLK_PERIOD_NS  = 5;
    localparam int SCLK_PERIOD_NS = 125;
    // divider half period, rounded down so the link never runs slow
    localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    // least gap after a frame closes, rounded up
    localparam int GAP_NS         = 1000;
    localparam int GAP_CYC        = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
    localparam logic [7:0] GAP_LAST  = 8'(GAP_CYC - 1);

    // ============================================================
    // frame layout
    // ============================================================
    localparam int FRAME_BITS = 29;
    localparam int FB_RW      = 28;
    localparam int FB_ADDR_HI = 27;
    localparam int FB_ADDR_LO = 16;
    localparam int FB_BUSY    = 15;
    localparam int FB_NACK    = 13;
    localparam int FB_REJ     = 12;
    localparam int FB_DATA_HI = 7;
    localparam logic [4:0] BIT_LAST = 5'(FRAME_BITS - 1);

    // ============================================================
    // address regions, taken from address bits 11:8
    // ============================================================
    localparam logic [3:0] RGN_P0_PRI = 4'h0;
    localparam logic [3:0] RGN_P0_SEC = 4'h1;
    localparam logic [3:0] RGN_P1_PRI = 4'h4;
    localparam logic [3:0] RGN_P1_SEC = 4'h5;
    localparam logic [3:0] RGN_LOCAL  = 4'h8;
    localparam int         NUM_PORTS  = 2;
    localparam int         LOCAL_WORDS = 256;

    // ============================================================
    // host controller registers on the AXI4-Lite side
    // ============================================================
    localparam logic [7:0] HOST_CTRL_OFF = 8'h00;
    localparam logic [7:0] HOST_TX_OFF   = 8'h04;
    localparam logic [7:0] HOST_RX_OFF   = 8'h08;
    localparam logic [7:0] HOST_STAT_OFF = 8'h0C;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_LAST_BIT  = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_OPEN_BIT  = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOW  = 3'b001,
        ST_HIGH = 3'b010,
        ST_TAIL = 3'b011,
        ST_GAP  = 3'b100
    } schp_host_state_type;

endpackage

/* schp_link_if.sv */
`timescale 1ns/100ps
// ============================================================
// serial chain link between host end and device end
// ============================================================
interface schp_link_if;
    logic serial_clock_pin;
    logic frame_select_pin;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_out_oe;
    logic serial_out_line;

    // undriven line idles high, as a pull-up would leave it
    assign serial_out_line = serial_out_oe ? serial_out_pin : 1'b1;

    modport host (
        output serial_clock_pin,
        output frame_select_pin,
        output serial_in_pin,
        input  serial_out_line
    );

    modport device (
        input  serial_clock_pin,
        input  frame_select_pin,
        input  serial_in_pin,
        output serial_out_pin,
        output serial_out_oe
    );
endinterface

/* schp_device_end.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module schp_device_end
    import schp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    schp_link_if.device      link,
    output logic             dn_req_valid,
    output logic             dn_req_port,
    output logic             dn_req_secondary,
    output logic             dn_req_read,
    output logic [7:0]       dn_req_offset,
    output logic [7:0]       dn_req_data,
    input  wire logic        dn_done,
    input  wire logic        dn_done_port,
    input  wire logic        dn_done_nack,
    input  wire logic [7:0]  dn_done_data
);

    // ============================================================
    // pin synchronisers and edge detection
    // ============================================================
    logic [1:0]  sclk_sync_ff;
    logic [1:0]  ss_sync_ff;
    logic [1:0]  mosi_sync_ff;
    logic        sclk_prev_ff;
    logic        ss_prev_ff;
    logic        sel_low;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        frame_start;
    logic        frame_end;

    // all three pins share one delay so their timing stays aligned
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_sync_ff <= 2'h0;
            ss_sync_ff   <= 2'h3;
            mosi_sync_ff <= 2'h0;
            sclk_prev_ff <= 1'b0;
            ss_prev_ff   <= 1'b1;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], link.serial_clock_pin};
            ss_sync_ff   <= {ss_sync_ff[0], link.frame_select_pin};
            mosi_sync_ff <= {mosi_sync_ff[0], link.serial_in_pin};
            sclk_prev_ff <= sclk_sync_ff[1];
            ss_prev_ff   <= ss_sync_ff[1];
        end
    end

    // clock edges count only inside a frame
    assign sel_low     = ~ss_sync_ff[1];
    assign sclk_rise   = sel_low & sclk_sync_ff[1] & ~sclk_prev_ff;
    assign sclk_fall   = sel_low & ~sclk_sync_ff[1] & sclk_prev_ff;
    assign frame_start = ~ss_sync_ff[1] & ss_prev_ff;
    assign frame_end   = ss_sync_ff[1] & ~ss_prev_ff;

    // ============================================================
    // frame shift register
    // ============================================================
    logic [FRAME_BITS-1:0] shift_ff;
    logic                  in_bit_ff;
    logic                  miso_ff;
    logic [FRAME_BITS-1:0] result_word;

    // load the stored result at frame start, then one bit per clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_ff  <= '0;
            in_bit_ff <= 1'b0;
            miso_ff   <= 1'b0;
        end else if (frame_start) begin
            shift_ff <= result_word;
            miso_ff  <= result_word[FB_RW];
        end else if (sclk_rise) begin
            in_bit_ff <= mosi_sync_ff[1];
        end else if (sclk_fall) begin
            shift_ff <= {shift_ff[FRAME_BITS-2:0], in_bit_ff};
            miso_ff  <= shift_ff[FRAME_BITS-2];
        end
    end

    // driver follows the pin itself, no clock in the path
    assign link.serial_out_pin = miso_ff;
    assign link.serial_out_oe  = ~link.frame_select_pin;

    // ============================================================
    // command decode
    // ============================================================
    logic        cmd_read;
    logic [11:0] cmd_addr;
    logic [7:0]  cmd_data;
    logic [3:0]  cmd_region;
    logic        cmd_dummy;
    logic        cmd_is_dn;
    logic        cmd_is_local;
    logic        cmd_port;
    logic        cmd_secondary;
    logic        port_busy;
    logic        accept_dn;
    logic        refuse_dn;
    logic        act;

    assign cmd_read   = shift_ff[FB_RW];
    assign cmd_addr   = shift_ff[FB_ADDR_HI:FB_ADDR_LO];
    assign cmd_data   = shift_ff[FB_DATA_HI:0];
    assign cmd_region = cmd_addr[11:8];
    assign cmd_dummy  = &shift_ff;
    // address decode by region
    assign cmd_is_dn  = (cmd_region == RGN_P0_PRI) | (cmd_region == RGN_P0_SEC)
                      | (cmd_region == RGN_P1_PRI) | (cmd_region == RGN_P1_SEC);
    assign cmd_is_local  = (cmd_region == RGN_LOCAL);
    assign cmd_port      = cmd_region[2];
    assign cmd_secondary = cmd_region[0];

    // ============================================================
    // per-port outstanding access tracking
    // ============================================================
    logic [NUM_PORTS-1:0] pend_ff;

    assign port_busy = pend_ff[cmd_port];
    assign act       = frame_end & ~cmd_dummy;
    assign accept_dn = act & cmd_is_dn & ~port_busy;
    assign refuse_dn = act & cmd_is_dn & port_busy;

    // set on accept, clear on completion; a busy port cannot accept,
    // so set and clear never meet on one port
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pend_ff[gp] <= 1'b0;
                end else if (accept_dn && (cmd_port == 1'(gp))) begin
                    pend_ff[gp] <= 1'b1;
                end else if (dn_done && (dn_done_port == 1'(gp))) begin
                    pend_ff[gp] <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // downstream request strobe
    // ============================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dn_req_valid     <= 1'b0;
            dn_req_port      <= 1'b0;
            dn_req_secondary <= 1'b0;
            dn_req_read      <= 1'b0;
            dn_req_offset    <= 8'h00;
            dn_req_data      <= 8'h00;
        end else begin
            dn_req_valid <= accept_dn;
            if (accept_dn) begin
                dn_req_port      <= cmd_port;
                dn_req_secondary <= cmd_secondary;
                dn_req_read      <= cmd_read;
                dn_req_offset    <= cmd_addr[7:0];
                dn_req_data      <= cmd_data;
            end
        end
    end

    // ============================================================
    // local register block
    // ============================================================
    logic [7:0] local_mem [0:LOCAL_WORDS-1];

    // plain storage; written the same cycle the frame closes
    always_ff @(posedge aclk) begin
        if (act && cmd_is_local && !cmd_read) begin
            local_mem[cmd_addr[7:0]] <= cmd_data;
        end
    end

    // ============================================================
    // result held for the next frame
    // ============================================================
    logic        res_read_ff;
    logic [11:0] res_addr_ff;
    logic        res_busy_ff;
    logic        res_nack_ff;
    logic        res_rej_ff;
    logic [7:0]  res_data_ff;
    logic        res_wait_ff;
    logic        res_port_ff;

    // a new command replaces the result; a late completion for an
    // overwritten command is dropped, which is why the host must wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_read_ff <= 1'b0;
            res_addr_ff <= 12'h000;
            res_busy_ff <= 1'b0;
            res_nack_ff <= 1'b0;
            res_rej_ff  <= 1'b0;
            res_data_ff <= 8'h00;
            res_wait_ff <= 1'b0;
            res_port_ff <= 1'b0;
        end else if (act) begin
            res_read_ff <= cmd_read;
            res_addr_ff <= cmd_addr;
            res_nack_ff <= 1'b0;
            res_rej_ff  <= refuse_dn;
            res_busy_ff <= accept_dn & cmd_read;
            res_wait_ff <= accept_dn;
            res_port_ff <= cmd_port;
            // local reads resolve at once, well inside the gap
            if (cmd_is_local && cmd_read) begin
                res_data_ff <= local_mem[cmd_addr[7:0]];
            end else begin
                res_data_ff <= 8'h00;
            end
        end else if (dn_done && res_wait_ff && (dn_done_port == res_port_ff)) begin
            res_busy_ff <= 1'b0;
            res_wait_ff <= 1'b0;
            res_nack_ff <= dn_done_nack;
            if (res_read_ff) begin
                res_data_ff <= dn_done_data;
            end
        end
    end

    // unused bits go out as zero
    assign result_word = {res_read_ff, res_addr_ff, res_busy_ff, 1'b0,
                          res_nack_ff, res_rej_ff, 4'h0, res_data_ff};

endmodule

/* schp_host_end.sv */
`timescale 1ns/100ps
module schp_host_end
    import schp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    schp_link_if.host        link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ============================================================
    // register bus
    // ============================================================
    schp_host_state_type   state_ff;
    logic [FRAME_BITS-1:0] tx_ff;
    logic [FRAME_BITS-1:0] rx_ff;
    logic                  ss_n_ff;
    logic                  wr_take;
    logic                  rd_take;
    logic                  start_req;

    // address and data are taken together, one write at a time
    assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_take;
    // a start while busy is dropped
    assign start_req = wr_take & (s_axi_awaddr == HOST_CTRL_OFF) & s_axi_wstrb[0]
                     & s_axi_wdata[CTRL_START_BIT] & (state_ff == ST_IDLE);

    // write response one cycle after the take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ((s_axi_awaddr == HOST_CTRL_OFF) ||
                             (s_axi_awaddr == HOST_TX_OFF)) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // transmit word, byte lanes honoured
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            localparam int HI = (gb == 3) ? FRAME_BITS - 1 : gb * 8 + 7;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    tx_ff[HI:gb*8] <= '0;
                end else if (wr_take && (s_axi_awaddr == HOST_TX_OFF) && s_axi_wstrb[gb]) begin
                    tx_ff[HI:gb*8] <= s_axi_wdata[HI:gb*8];
                end
            end
        end
    endgenerate

    // read data one cycle after the take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                HOST_TX_OFF:   s_axi_rdata <= {3'h0, tx_ff};
                HOST_RX_OFF:   s_axi_rdata <= {3'h0, rx_ff};
                HOST_STAT_OFF: s_axi_rdata <= {30'h0000_0000, ~ss_n_ff, state_ff != ST_IDLE};
                HOST_CTRL_OFF: s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // link engine
    // ============================================================
    logic [1:0]            miso_sync_ff;
    logic [FRAME_BITS-1:0] tx_sh_ff;
    logic [FRAME_BITS-1:0] rx_sh_ff;
    logic [7:0]            cnt_ff;
    logic [4:0]            bit_ff;
    logic                  last_ff;
    logic                  sclk_ff;
    logic                  mosi_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            miso_sync_ff <= 2'h3;
        end else begin
            miso_sync_ff <= {miso_sync_ff[0], link.serial_out_line};
        end
    end

    // sclk idles low; data changes at fall, sampled at rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            ss_n_ff  <= 1'b1;
            sclk_ff  <= 1'b0;
            mosi_ff  <= 1'b0;
            cnt_ff   <= 8'h00;
            bit_ff   <= 5'h00;
            last_ff  <= 1'b0;
            tx_sh_ff <= '0;
            rx_sh_ff <= '0;
            rx_ff    <= '0;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
            unique case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= 8'h00;
                    if (start_req) begin
                        ss_n_ff  <= 1'b0;
                        tx_sh_ff <= tx_ff;
                        mosi_ff  <= tx_ff[FB_RW];
                        last_ff  <= s_axi_wdata[CTRL_LAST_BIT];
                        bit_ff   <= 5'h00;
                        state_ff <= ST_LOW;
                    end
                end
                ST_LOW: if (cnt_ff == HALF_LAST) begin
                    cnt_ff   <= 8'h00;
                    sclk_ff  <= 1'b1;
                    rx_sh_ff <= {rx_sh_ff[FRAME_BITS-2:0], miso_sync_ff[1]};
                    state_ff <= ST_HIGH;
                end
                ST_HIGH: if (cnt_ff == HALF_LAST) begin
                    cnt_ff  <= 8'h00;
                    sclk_ff <= 1'b0;
                    bit_ff  <= bit_ff + 5'h01;
                    if (bit_ff == BIT_LAST) begin
                        state_ff <= ST_TAIL;
                    end else begin
                        tx_sh_ff <= {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
                        mosi_ff  <= tx_sh_ff[FRAME_BITS-2];
                        state_ff <= ST_LOW;
                    end
                end
                ST_TAIL: if (cnt_ff == HALF_LAST) begin
                    cnt_ff <= 8'h00;
                    rx_ff  <= rx_sh_ff;
                    if (last_ff) begin
                        ss_n_ff  <= 1'b1;
                        state_ff <= ST_GAP;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_GAP: if (cnt_ff == GAP_LAST) begin
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign link.serial_clock_pin = sclk_ff;
    assign link.frame_select_pin = ss_n_ff;
    assign link.serial_in_pin    = mosi_ff;

endmodule

/* schp_link_props.sv */
`timescale 1ns/100ps
// ==========
// link checker
module schp_link_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_clock_pin,
    input wire logic frame_select_pin,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    logic [7:0] rise_ff;
    logic [7:0] idle_ff;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // link rises seen in the open frame
    always_ff @(posedge aclk) begin
        if (!aresetn || frame_select_pin) rise_ff <= 8'h00;
        else rise_ff <= rise_ff + 8'($rose(serial_clock_pin));
    end
    // idle cycles, saturated; reset counts as a long gap
    always_ff @(posedge aclk) begin
        if (!aresetn) idle_ff <= 8'hFF;
        else if (!frame_select_pin) idle_ff <= 8'h00;
        else if (idle_ff != 8'hFF) idle_ff <= idle_ff + 8'h01;
    end
    sequence hi_phase;
        serial_clock_pin[*8] ##1 serial_clock_pin[*3];
    endsequence
    sequence lo_lead;
        (!serial_clock_pin)[*8];
    endsequence
    chk_oe_tracks: assert property (serial_out_oe == !frame_select_pin)
        else $error("output enable not tracking select");
    chk_clock_idle: assert property (frame_select_pin |-> !serial_clock_pin)
        else $error("link clock moves while deselected");
    chk_half_period: assert property ($rose(serial_clock_pin) |=> hi_phase ##1 !serial_clock_pin)
        else $error("link clock high phase wrong");
    chk_lead_time: assert property ($fell(frame_select_pin) |-> lo_lead)
        else $error("link clock rose too soon after select");
    chk_in_stable: assert property ($rose(serial_clock_pin) |-> $stable(serial_in_pin))
        else $error("input data moved at rising edge");
    chk_out_stable: assert property ($rose(serial_clock_pin) |-> ##5 $stable(serial_out_pin)[*6])
        else $error("output data moved in high phase");
    chk_bit_count: assert property ($rose(frame_select_pin) |-> rise_ff == 8'h1D)
        else $error("frame length not 29 bits");
    chk_gap_kept: assert property ($fell(frame_select_pin) |-> idle_ff >= 8'hC8)
        else $error("gap between frames too short");
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
    import schp_pkg::*;
;
    typedef struct packed {
        logic [28:0] tx;
        logic [28:0] ex;
        logic        ck;
        logic        rq;
        logic        dn;
        logic [9:0]  dd;
    } schp_row_type;
    localparam logic [28:0] FF = 29'h1FFFFFFF;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dn_done_data = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic dn_done = 1'b0, dn_done_port = 1'b0, dn_done_nack = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic dn_req_valid, dn_req_port, dn_req_secondary, dn_req_read;
    logic [7:0] dn_req_offset, dn_req_data;
    wire [18:0] dreq = {dn_req_port, dn_req_secondary, dn_req_read, dn_req_offset, dn_req_data};
    int mismatches = 0, checked = 0, reqs = 0, ereq = 0;
    schp_row_type rows [11];
    schp_link_if link();
    schp_host_end i_schp_host_end (.*);
    schp_device_end i_schp_device_end (.*);
    schp_link_props i_schp_link_props (.aclk(aclk), .aresetn(aresetn),
        .serial_clock_pin(link.serial_clock_pin), .frame_select_pin(link.frame_select_pin),
        .serial_in_pin(link.serial_in_pin), .serial_out_pin(link.serial_out_pin),
        .serial_out_oe(link.serial_out_oe));
    // ==========
    // helpers
    function automatic logic [28:0] mk(input logic r, input logic [11:0] a, input logic [7:0] d);
        mk = {r, a, 8'h00, d};
    endfunction
    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            final_report();
        end
    endtask
    // write and read hold valid until taken; ready lines stay high
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        logic aw = 1'b1;
        logic w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // each channel drops only once its own ready is seen
        do begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end while ((aw || w) && ++n < 99);
        do @(posedge aclk); while (!s_axi_bvalid && ++n < 99);
        rr = s_axi_bresp;
        tmo(n, 99);
    endtask
    task automatic axr(input logic [7:0] a);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready && ++n < 99);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid && ++n < 99);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        tmo(n, 99);
    endtask
    // one closed frame, then fetch what came back
    task automatic frame(input logic [28:0] tx);
        int n = 0;
        axw(HOST_TX_OFF, {3'b000, tx});
        axw(HOST_CTRL_OFF, 32'h3);
        do axr(HOST_STAT_OFF); while (rd[1:0] !== 2'b00 && ++n < 999);
        tmo(n, 999);
        axr(HOST_RX_OFF);
    endtask
    task automatic done(input logic [9:0] d);
        {dn_done_port, dn_done_nack, dn_done_data} <= d;
        dn_done <= 1'b1;
        @(posedge aclk);
        dn_done <= 1'b0;
        @(posedge aclk);
    endtask
    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) if (dn_req_valid === 1'b1) reqs++;
    // ==========
    // main sequence
    initial begin
        rows[0] = '{FF, '0, 0, 0, 0, '0};
        rows[1] = '{mk(0, 12'h805, 8'hA5), '0, 0, 0, 0, '0};
        rows[2] = '{mk(1, 12'h805, 8'h00), mk(0, 12'h805, 8'h00), 1, 0, 0, '0};
        rows[3] = '{FF, mk(1, 12'h805, 8'hA5), 1, 0, 0, '0};
        rows[4] = '{mk(0, 12'h3FF, 8'h00), mk(1, 12'h805, 8'hA5), 1, 0, 0, '0};
        rows[5] = '{mk(0, 12'h512, 8'h3C), mk(0, 12'h3FF, 8'h00), 1, 1, 1, 10'h200};
        rows[6] = '{mk(1, 12'h0A0, 8'h00), mk(0, 12'h512, 8'h00), 1, 1, 0, '0};
        rows[7] = '{mk(1, 12'h0A2, 8'h00), mk(1, 12'h0A0, 8'h00) | 29'h8000, 1, 0, 1, 10'h15A};
        rows[8] = '{mk(1, 12'h0A0, 8'h00), mk(1, 12'h0A2, 8'h00) | 29'h1000, 1, 1, 1, 10'h15A};
        rows[9] = '{FF, mk(1, 12'h0A0, 8'h5A) | 29'h2000, 1, 0, 0, '0};
        rows[10] = '{mk(0, 12'h4C7, 8'h96), mk(1, 12'h0A0, 8'h5A) | 29'h2000, 1, 1, 0, '0};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i]) begin
            frame(rows[i].tx);
            if (rows[i].ck) cmp("rx", {3'b000, rows[i].ex}, rd);
            ereq += int'(rows[i].rq);
            cmp("reqs", ereq, reqs);
            if (i == 5) cmp("req5", {3'b110, 8'h12, 8'h3C}, dreq);
            if (rows[i].dn) done(rows[i].dd);
            $display("row %0d done", i);
        end
        cmp("req", {3'b100, 8'hC7, 8'h96}, dreq);
        axw(8'h10, 32'h0);
        cmp("bresp", RESP_SLVERR, rr);
        axr(8'h10);
        cmp("resp", RESP_SLVERR, rr);
        axr(HOST_TX_OFF);
        cmp("tx", {3'b000, mk(0, 12'h4C7, 8'h96)}, rd);
        $display("host test done");
        // reset cuts an open frame; the next frame must see a cleared result
        axw(HOST_CTRL_OFF, 32'h3);
        repeat (50) @(posedge aclk);
        cmp("open", 0, link.frame_select_pin);
        cmp("oe_on", 1, link.serial_out_oe);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        cmp("sel", 1, link.frame_select_pin);
        cmp("oe", 0, link.serial_out_oe);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cmp("sck", 0, link.serial_clock_pin);
        cmp("sel2", 1, link.frame_select_pin);
        $display("reset test done");
        frame(FF);
        cmp("rx0", 0, rd);
        cmp("reqs", ereq, reqs);
        $display("restart test done");
        final_report();
    end
endmodule
